// *** core/iabi_cfg.svh ***
// Constants of the integrating converter bus interface
// Notes on behaviour
// RULE1: Internal counter clock is the oscillator input divided by four.
// RULE2: Every conversion cycle lasts exactly 1280 internal clock periods.
// RULE3: Mode input high gives continuous conversions, low gives on-request.
// RULE4: On request, one conversion per qualified low pulse of convert strobe.
// RULE5: New result is latched and valid when busy falls.
// RULE6: Continuous: result valid 443.5 cycles after busy falls, then cleared; the code clears it after 444.
// RULE7: Host must finish three continuous reads within 443.5 cycles.
// RULE8: Continuous mode ignores byte select and top flag choice.
// RULE9: Continuous order: high byte with sign, low byte, high with overrange.
// RULE10: Continuous byte counter advances on each read strobe rising edge; the code stops advancing it after the third read.
// RULE11: Host returns read strobe high after each byte; selects may stay on.
// RULE12: High byte, flag choice low: bits 14..8 plus sign on top line.
// RULE13: High byte, flag choice high: bits 14..8 plus overrange on top line.
// RULE14: Low byte selected: bits 7..0; flag choice has no effect.
// RULE15: Chip enable low AND chip select high qualify read and convert strobes.
// RULE16: Data lines driven only while selected and read strobe low.
// RULE17: Bus contents during a convert strobe are ignored.
// RULE18: Up to 191 counts beyond full scale, reported with overrange set.
// RULE19: Busy rises in signal integrate, 58 periods before deintegrate start, falls at cycle end, 836 periods high.
// RULE20: On request, bytes readable in any order until next convert pulse.
// RULE21: Phases: 246 zero, 256 signal, 778 reference integrate cycles.
// RULE22: Convert request taken at strobe rising edge; ignored while converting.
// RULE23: Host strobes and selects are synchronised before use.
`ifndef IABI_CFG_SVH
`define IABI_CFG_SVH
`define IABI_OSC_DIV 4
`define IABI_ZI_CYC 246
`define IABI_SI_CYC 256
`define IABI_RI_CYC 778
`define IABI_CONV_CYC 1280
`define IABI_BUSY_CYC 836
`define IABI_HOLD_CYC 443
`define IABI_OVR_MAX 191
`define IABI_FIFO_DEPTH 8
`define IABI_FIFO_WIDTH 17
`endif

// *** core/iabi_pkg.sv ***
// Types of the integrating converter bus interface
package iabi_pkg;
   typedef enum logic [1:0] {
      IABI_IDLE = 2'b00,
      IABI_ZERO = 2'b01,
      IABI_SIG = 2'b10,
      IABI_REF = 2'b11
   } iabi_phase_type;
endpackage

// *** core/iabi_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module iabi_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rd_r];
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_r[wr_r] <= in_data_i;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// *** core/iabi_sync.sv ***
// Two-flop synchroniser for a group of host inputs
`timescale 1ns/100ps
module iabi_sync #(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule

// *** core/iabi_top.sv ***
// Control and bus interface of an integrating converter
`timescale 1ns/100ps
`include "iabi_cfg.svh"
module iabi_top
   import iabi_pkg::*;
#(
   parameter int DIV = `IABI_OSC_DIV,
   parameter int ZI_CYC = `IABI_ZI_CYC,
   parameter int SI_CYC = `IABI_SI_CYC,
   parameter int RI_CYC = `IABI_RI_CYC,
   parameter int BUSY_CYC = `IABI_BUSY_CYC,
   parameter int HOLD_CYC = `IABI_HOLD_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Mode and byte selection
   input wire logic conversion_mode_select_i,
   input wire logic top_flag_choice_i,
   input wire logic low_byte_sel_i,
   // Host strobes
   input wire logic chip_enable_n_i,
   input wire logic chip_select_i,
   input wire logic read_n_i,
   input wire logic convert_n_i,
   // Comparator result from analog section
   input wire logic [14:0] meas_count_i,
   input wire logic meas_positive_i,
   input wire logic meas_overrange_i,
   // Data bus
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   // Status
   output logic busy_o,
   output logic [1:0] phase_o,
   output logic result_valid_o
);
   // ****************************************
   // Input synchronisation
   // ****************************************
   logic [5:0] sync_w;
   iabi_sync #(.WIDTH(6)) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i({conversion_mode_select_i, top_flag_choice_i, low_byte_sel_i,
                ~chip_enable_n_i & chip_select_i, read_n_i, convert_n_i}),
      .sync_o(sync_w)
   ); // RULE23
   wire cont_w = sync_w[5];
   wire flag_w = sync_w[4];
   wire low_w = sync_w[3];
   wire sel_w = sync_w[2]; // RULE15
   wire rd_n_w = sync_w[1];
   wire wr_n_w = sync_w[0];

   logic rd_n_d_r;
   logic wr_q_r;
   // Strobe counts only while qualified; bus data is never sampled
   wire rd_rise_w = sel_w && rd_n_w && !rd_n_d_r; // RULE10
   wire wr_rise_w = wr_q_r && wr_n_w; // RULE17 RULE22

   // ****************************************
   // Divide-by-four tick and sequencer
   // ****************************************
   logic [$clog2(DIV)-1:0] div_r;
   wire tick_w = (div_r == ($clog2(DIV))'(DIV-1)); // RULE1
   iabi_phase_type phase_r;
   iabi_phase_type phase_nxt;
   logic [10:0] cnt_r;
   logic busy_r;
   logic [10:0] since_fall_r;
   logic hold_r;

   wire zero_end_w = (cnt_r == 11'(ZI_CYC-1));
   wire sig_end_w = (cnt_r == 11'(SI_CYC-1));
   wire ref_end_w = (cnt_r == 11'(RI_CYC-1));
   wire start_w = (phase_r == IABI_IDLE) && !busy_r && (cont_w || wr_rise_w); // RULE3 RULE4
   wire end_w = tick_w && (phase_r == IABI_REF) && ref_end_w; // RULE2
   // Busy spans the last 836 of the 1280 cycles, so it rises inside the signal phase
   // Limitation: BUSY_CYC must lie between RI_CYC and RI_CYC plus SI_CYC
   localparam int LEAD = BUSY_CYC - RI_CYC;
   wire busy_at_w = (cnt_r == 11'(SI_CYC - LEAD - 1));
   wire busy_set_w = tick_w && (phase_r == IABI_SIG) && busy_at_w; // RULE19
   // Continuous data discarded on the same tick as the next busy rise
   wire expire_w = hold_r && cont_w && tick_w && (since_fall_r == 11'(HOLD_CYC)); // RULE6

   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         IABI_IDLE: phase_nxt = start_w ? IABI_ZERO : IABI_IDLE;
         IABI_ZERO: phase_nxt = (tick_w && zero_end_w) ? IABI_SIG : IABI_ZERO; // RULE21
         IABI_SIG: phase_nxt = (tick_w && sig_end_w) ? IABI_REF : IABI_SIG;
         IABI_REF: begin
            if (end_w) begin
               phase_nxt = cont_w ? IABI_ZERO : IABI_IDLE; // RULE3
            end
         end
         default: phase_nxt = IABI_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         div_r <= '0;
         phase_r <= IABI_IDLE;
         cnt_r <= '0;
         rd_n_d_r <= 1'b1;
         wr_q_r <= 1'b0;
      end else begin
         div_r <= (phase_r == IABI_IDLE) ? '0 : (tick_w ? '0 : div_r + 1'b1);
         phase_r <= phase_nxt;
         if (phase_r != phase_nxt || phase_r == IABI_IDLE) begin
            cnt_r <= '0;
         end else if (tick_w) begin
            cnt_r <= cnt_r + 11'h001;
         end
         rd_n_d_r <= rd_n_w;
         // Request armed by a qualified low level, ignored outside the idle phase
         wr_q_r <= sel_w && !wr_n_w && phase_r == IABI_IDLE; // RULE22
      end
   end

   // ****************************************
   // Result latch and byte counter
   // ****************************************
   logic [14:0] mag_r;
   logic pos_r;
   logic ovr_r;
   logic [1:0] byte_r;
   logic [16:0] res_w;
   logic res_valid_w;
   // Result word queued at conversion end; drained at once into the latch
   iabi_fifo #(.WIDTH(`IABI_FIFO_WIDTH), .DEPTH(`IABI_FIFO_DEPTH)) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .in_valid_i(end_w),
      .in_ready_o(),
      .in_data_i({meas_overrange_i, meas_positive_i, meas_count_i}),
      .out_valid_o(res_valid_w),
      .out_ready_i(1'b1),
      .out_data_o(res_w)
   );
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mag_r <= 15'h0000;
         pos_r <= 1'b0;
         ovr_r <= 1'b0;
      end else if (res_valid_w) begin
         // Overrange keeps only the low byte count
         mag_r <= res_w[16] ? {7'h00, res_w[7:0]} : res_w[14:0]; // RULE5 RULE18
         pos_r <= res_w[15];
         ovr_r <= res_w[16];
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         busy_r <= 1'b0;
         hold_r <= 1'b0;
         since_fall_r <= '0;
         byte_r <= 2'h0;
      end else begin
         if (busy_set_w) begin
            busy_r <= 1'b1;
         end else if (end_w) begin
            busy_r <= 1'b0;
         end
         if (end_w) begin
            hold_r <= 1'b1;
            since_fall_r <= '0;
            byte_r <= 2'h0;
         end else begin
            if (tick_w && hold_r) begin
               since_fall_r <= since_fall_r + 11'h001;
            end
            if (expire_w) begin
               hold_r <= 1'b0;
               byte_r <= 2'h0;
            end else if (!cont_w && wr_rise_w) begin
               hold_r <= 1'b0; // RULE20
            end else if (cont_w && rd_rise_w && byte_r != 2'h3) begin
               byte_r <= byte_r + 2'h1; // RULE10
            end
         end
      end
   end

   // ****************************************
   // Bus output selection
   // ****************************************
   wire [7:0] hi_pol_w = {pos_r, mag_r[14:8]}; // RULE12
   wire [7:0] hi_ovr_w = {ovr_r, mag_r[14:8]}; // RULE13
   wire [7:0] lo_w = mag_r[7:0]; // RULE14
   // Mode selection overrides both select pins in continuous mode
   wire [7:0] cont_byte_w = (byte_r == 2'h1) ? lo_w :
                            (byte_r == 2'h0) ? hi_pol_w : hi_ovr_w; // RULE8 RULE9
   wire [7:0] dem_byte_w = low_w ? lo_w : (flag_w ? hi_ovr_w : hi_pol_w);
   wire drive_w = sel_w && !rd_n_w; // RULE16

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         data_o <= 8'h00;
         data_oe_o <= 1'b0;
         busy_o <= 1'b0;
         phase_o <= 2'h0;
         result_valid_o <= 1'b0;
      end else begin
         data_o <= cont_w ? cont_byte_w : dem_byte_w;
         data_oe_o <= drive_w;
         busy_o <= busy_r;
         phase_o <= phase_r;
         result_valid_o <= hold_r && !busy_r;
      end
   end
endmodule

// *** tb/iabi_host.sv ***
// Host bus model for the converter interface
`timescale 1ns/100ps
module iabi_host (
   // Clock
   input wire logic sys_clk_i,
   // Device bus outputs
   input wire logic [7:0] data_o,
   input wire logic data_oe_o,
   // Host strobes and bus
   output logic chip_enable_n_o,
   output logic chip_select_o,
   output logic read_n_o,
   output logic convert_n_o,
   output logic [7:0] bus_o
);
   initial begin
      chip_enable_n_o = 1'b1;
      chip_select_o = 1'b0;
      read_n_o = 1'b1;
      convert_n_o = 1'b1;
      bus_o = 8'h5A;
   end
   // Bus content keeps changing, so storing it would show
   always @(posedge sys_clk_i) begin
      bus_o <= ~bus_o;
   end
   task automatic sel(input logic on);
      @(posedge sys_clk_i);
      chip_enable_n_o <= !on;
      chip_select_o <= on;
   endtask
   task automatic cv();
      @(posedge sys_clk_i);
      convert_n_o <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      convert_n_o <= 1'b1;
   endtask
   // Gap stretches the strobe to model a slow host
   task automatic rd(input int gap, output logic [7:0] b);
      @(posedge sys_clk_i);
      read_n_o <= 1'b0;
      repeat (4 + gap) @(posedge sys_clk_i);
      b = data_oe_o ? data_o : 8'hXX;
      read_n_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
   endtask
endmodule

// *** tb/iabi_top_asserts.sv ***
// Port timing checker for the converter interface
`timescale 1ns/100ps
module iabi_top_asserts #(
   parameter int DIV = 4,
   parameter int BUSY_CYC = 836,
   parameter int HOLD_CYC = 443
) (
   // Watched ports
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic conversion_mode_select_i,
   input wire logic chip_enable_n_i,
   input wire logic chip_select_i,
   input wire logic read_n_i,
   input wire logic convert_n_i,
   input wire logic data_oe_o,
   input wire logic busy_o,
   input wire logic [1:0] phase_o,
   input wire logic result_valid_o
);
   localparam int BW = BUSY_CYC * DIV - 1;
   // First sample after busy falls at which the continuous result is gone
   localparam int HEND = HOLD_CYC * DIV + 4;
   logic [11:0] low_cnt_r;
   logic cont_r;
   // Cycles since busy fell, and the mode of the conversion that ended
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         low_cnt_r <= '0;
         cont_r <= 1'b0;
      end else if (busy_o) begin
         low_cnt_r <= '0;
         cont_r <= conversion_mode_select_i;
      end else if (low_cnt_r != 12'hFFF) begin
         low_cnt_r <= low_cnt_r + 12'h001;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_oe_follows_sel: assert property (data_oe_o ==
      $past(chip_select_i && !chip_enable_n_i && !read_n_i, 3)) else $error("bus enable wrong");
   a_busy_width: assert property ($rose(busy_o) |-> ##BW busy_o ##1 !busy_o)
      else $error("busy width wrong");
   a_phase_order: assert property ($changed(phase_o) && phase_o[1]
      |-> $past(phase_o) == phase_o - 2'h1) else $error("phase order wrong");
   a_valid_at_fall: assert property ($fell(busy_o) |-> ##[0:1] result_valid_o)
      else $error("result not valid at busy fall");
   a_valid_not_busy: assert property (result_valid_o |-> !busy_o)
      else $error("valid while busy");
   a_cont_hold: assert property (cont_r && low_cnt_r == 12'(HEND - 1)
      |-> result_valid_o) else $error("continuous result dropped early");
   a_cont_expire: assert property (cont_r && low_cnt_r == 12'(HEND)
      |-> !result_valid_o) else $error("continuous result not dropped");
   a_cont_restart: assert property ($fell(busy_o) && conversion_mode_select_i
      |-> ##[0:8] phase_o == 2'h1) else $error("no back-to-back conversion");
   a_demand_idle: assert property ((!conversion_mode_select_i && convert_n_i
      && phase_o == 2'h0) [*8] |=> phase_o == 2'h0) else $error("unrequested conversion");
   c_cont_done: cover property ($fell(busy_o) && conversion_mode_select_i);
   c_demand_done: cover property ($fell(busy_o) && !conversion_mode_select_i);
   c_bus_drive: cover property ($rose(data_oe_o));
endmodule
bind iabi_top iabi_top_asserts #(.DIV(DIV), .BUSY_CYC(BUSY_CYC), .HOLD_CYC(HOLD_CYC)) u_asserts (
   .sys_clk_i, .rst_i, .conversion_mode_select_i, .chip_enable_n_i, .chip_select_i,
   .read_n_i, .convert_n_i, .data_oe_o, .busy_o, .phase_o, .result_valid_o);

// *** tb/testbench.sv ***
// Self-checking bench for the converter interface
`timescale 1ns/100ps
`define CHK(nm, e, v) begin total_checks++; if ((v) !== (e)) begin bad_count++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, v); end end
module testbench;
   logic clk, rst, mode, flag, lsel, pos, ovr, ce_n, cs, rd_n, cv_n, oe, busy, valid;
   logic [14:0] meas;
   logic [7:0] bus, dout;
   logic [1:0] phase;
   int bad_count = 0;
   int total_checks = 0;
   // Short phases keep the run brief; busy leads reference by 4, hold ends as busy rises
   iabi_top #(.ZI_CYC(10), .SI_CYC(10), .RI_CYC(20), .BUSY_CYC(24), .HOLD_CYC(15)) uut (
      .sys_clk_i(clk), .rst_i(rst), .conversion_mode_select_i(mode),
      .top_flag_choice_i(flag), .low_byte_sel_i(lsel), .chip_enable_n_i(ce_n),
      .chip_select_i(cs), .read_n_i(rd_n), .convert_n_i(cv_n), .meas_count_i(meas),
      .meas_positive_i(pos), .meas_overrange_i(ovr), .data_i(bus), .data_o(dout),
      .data_oe_o(oe), .busy_o(busy), .phase_o(phase), .result_valid_o(valid));
   iabi_host host (.sys_clk_i(clk), .data_o(dout), .data_oe_o(oe), .chip_enable_n_o(ce_n),
      .chip_select_o(cs), .read_n_o(rd_n), .convert_n_o(cv_n), .bus_o(bus));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (busy !== 1'b1 && n < 400) begin @(posedge clk); n++; end
      while (busy !== 1'b0 && n < 400) begin @(posedge clk); n++; end
      `CHK("busy handshake", 1'b1, n < 400)
      @(posedge clk);
   endtask
   task automatic get(input int gap, input logic l, input logic f, input string nm,
                      input logic [7:0] e);
      logic [7:0] b;
      lsel <= l;
      flag <= f;
      host.rd(gap, b);
      `CHK(nm, e, b)
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      rst = 1'b1; mode = 1'b0; flag = 1'b0; lsel = 1'b0;
      meas = 15'h5A3C; pos = 1'b1; ovr = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("busy after reset", 1'b0, busy)
      host.cv();
      repeat (20) @(posedge clk);
      `CHK("unselected start", 2'h0, phase)
      host.sel(1'b1);
      host.cv();
      repeat (30) @(posedge clk);
      host.cv();
      wait_done();
      `CHK("request during run", 2'h0, phase)
      `CHK("demand valid", 1'b1, valid)
      meas <= 15'h0123;
      pos <= 1'b0;
      get(0, 1'b1, 1'b1, "low byte", 8'h3C);
      get(9, 1'b0, 1'b0, "high sign", 8'hDA);
      get(0, 1'b0, 1'b1, "high over", 8'h5A);
      `CHK("bus released", 1'b0, oe)
      meas <= 15'h00BE;
      pos <= 1'b1;
      ovr <= 1'b1;
      host.cv();
      wait_done();
      get(0, 1'b0, 1'b1, "overrange high", 8'h80);
      get(0, 1'b1, 1'b0, "overrange low", 8'hBE);
      meas <= 15'h1234;
      ovr <= 1'b0;
      mode <= 1'b1;
      wait_done();
      get(0, 1'b1, 1'b1, "cont first", 8'h92);
      get(0, 1'b0, 1'b0, "cont second", 8'h34);
      get(0, 1'b1, 1'b0, "cont third", 8'h12);
      get(0, 1'b0, 1'b1, "cont fourth", 8'h12);
      meas <= 15'h0456;
      pos <= 1'b0;
      wait_done();
      get(0, 1'b0, 1'b0, "next first", 8'h04);
      // Past expiry the byte counter restarts, so high byte comes again
      while (busy !== 1'b1) @(posedge clk);
      get(0, 1'b1, 1'b0, "expired restart", 8'h04);
      meas <= 15'h0777;
      pos <= 1'b1;
      wait_done();
      get(0, 1'b1, 1'b1, "restart first", 8'h87);
      end_of_test();
   end
endmodule
